// [tcsp_pkg.sv]
package tcsp_pkg;

    // register addresses
    localparam logic [15:0] TCSP_ADDR_MODE   = 16'hff80;
    localparam logic [15:0] TCSP_ADDR_CLKSEL = 16'hff81;
    localparam logic [15:0] TCSP_ADDR_TXBUF  = 16'hff82;
    localparam logic [15:0] TCSP_ADDR_SHIFT  = 16'hff83;

    // serial_mode_control field positions
    localparam int TCSP_MODE_EN_BIT   = 7;
    localparam int TCSP_MODE_TRMD_BIT = 6;
    localparam int TCSP_MODE_DIR_BIT  = 4;
    localparam int TCSP_MODE_BUSY_BIT = 0;

    // serial_clock_select_reg field positions
    localparam int TCSP_CSEL_CKP_BIT = 4;
    localparam int TCSP_CSEL_DAP_BIT = 3;

    // reset values
    localparam logic [7:0] TCSP_MODE_RST   = 8'h00;
    localparam logic [7:0] TCSP_CLKSEL_RST = 8'h00;

    // clock-select code that hands the serial clock to the outside master
    localparam logic [2:0] TCSP_CKS_EXT = 3'h7;

    // bits per transfer
    localparam logic [3:0] TCSP_BITS = 4'h8;

    // fifo depth in the receive path
    localparam int TCSP_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        TCSP_IDLE,
        TCSP_LEAD,
        TCSP_TRAIL
    } tcsp_state_t;

    // cpu-side register access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  wmask;
    } tcsp_cpu_req_t;

    // pin drive bundle: enables are low while driving
    typedef struct packed {
        logic sck_out;
        logic sck_oe_n;
        logic so_out;
        logic so_oe_n;
    } tcsp_pins_t;

endpackage : tcsp_pkg

// [tcsp_fifo.sv]
`timescale 1ns/100ps
module tcsp_fifo
    import tcsp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = TCSP_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clr_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } tcsp_fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    tcsp_fifo_st_t    st_r;
    tcsp_fifo_st_t    st_nxt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = mem[st_r.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (clr_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage holds no control, so it needs no reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st_r.wp] <= in_data_i;
        end
    end
endmodule : tcsp_fifo

// [tcsp_port.sv]
// What this block does
// - clearing enable stops all serial traffic
// - enable low holds serial logic in reset
// - enable low clears busy flag and shifter
// - mode register byte/bit writable, resets zero
// - mode layout bits 7,6,4,0; rest zero
// - three lines: clock, data out, data in
// - exactly eight bits, clocked by serial clock
// - tx/rx mode: buffer write starts transfer
// - receive mode: shift read starts reception
// - busy bit set throughout a transfer
// - after eight bits raise done, clear busy
// - unused pins stay general purpose port pins
// - codes 0-6 divide by 2..128, 7 external
// - direction 0 msb first, 1 lsb first
// - receive-only mode holds data out low with the pin released
`timescale 1ns/100ps
module tcsp_port
    import tcsp_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire tcsp_cpu_req_t cpu_i,
    output logic [7:0]         rdata_o,
    output logic               done_irq_flag_o,
    input  wire logic          sck_pin_i,
    input  wire logic          si_pin_i,
    output logic               sck_pin_o,
    output logic               sck_pin_oe_n_o,
    output logic               so_pin_o,
    output logic               so_pin_oe_n_o,
    output logic               rx_valid_o,
    input  wire logic          rx_ready_i,
    output logic [7:0]         rx_data_o
);
    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  csel;
        logic [7:0]  txbuf;
        logic [7:0]  shift;
        logic [3:0]  bits;
        logic [6:0]  div;
        tcsp_state_t fsm;
        logic        so;
        logic        sck;
        logic        ext_q;
        logic        done;
        logic [7:0]  rdata;
        tcsp_pins_t  pins;
    } tcsp_st_t;

    tcsp_st_t   st_r;
    tcsp_st_t   st_nxt;
    logic [1:0] sck_sync_r;
    logic [1:0] si_sync_r;
    logic       en;
    logic       trmd;
    logic       dir;
    logic       ckp;
    logic       dap;
    logic       slave;
    logic       tick;
    logic       lead_edge;
    logic       trail_edge;
    logic       start;
    logic       rx_push;
    logic       rx_room;

    // position-aware bit pick used for both the first bit and shifts
    function automatic logic pick_out(input logic [7:0] d, input logic lsb);
        pick_out = lsb ? d[0] : d[7];
    endfunction : pick_out

    function automatic logic [7:0] shift_in(input logic [7:0] d,
                                            input logic lsb,
                                            input logic b);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction : shift_in

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sck_sync_r <= 2'h0;
            si_sync_r  <= 2'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[0], sck_pin_i};
            si_sync_r  <= {si_sync_r[0], si_pin_i};
        end
    end

    assign en    = st_r.mode[TCSP_MODE_EN_BIT];
    assign trmd  = st_r.mode[TCSP_MODE_TRMD_BIT];
    assign dir   = st_r.mode[TCSP_MODE_DIR_BIT];
    assign ckp   = st_r.csel[TCSP_CSEL_CKP_BIT];
    assign dap   = st_r.csel[TCSP_CSEL_DAP_BIT];
    assign slave = (st_r.csel[2:0] == TCSP_CKS_EXT);

    // master clock: code n gives a half period of 2^n cycles, so the
    // serial clock runs at the system clock divided by 2^(n+1)
    assign tick = (st_r.div == (7'h1 << st_r.csel[2:0]) - 7'h1);

    // edges: master lead = leaving idle level ckp; external clock lead = returning to ckp
    always_comb begin
        lead_edge  = 1'b0;
        trail_edge = 1'b0;
        if (slave) begin
            lead_edge  = (st_r.ext_q != ckp) && (sck_sync_r[1] == ckp);
            trail_edge = (st_r.ext_q == ckp) && (sck_sync_r[1] != ckp);
        end else if (tick) begin
            lead_edge  = (st_r.fsm == TCSP_LEAD);
            trail_edge = (st_r.fsm == TCSP_TRAIL);
        end
    end

    // start triggers
    assign start = en && (st_r.fsm == TCSP_IDLE) &&
        ((trmd && cpu_i.wr && cpu_i.addr == TCSP_ADDR_TXBUF) ||
         (!trmd && cpu_i.rd && cpu_i.addr == TCSP_ADDR_SHIFT));

    ////////////////////////////////////////////////////////////////////////
    // register file, shift engine and pin drive
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        rx_push     = 1'b0;
        st_nxt.ext_q = sck_sync_r[1];

        // register writes with byte-lane bit mask
        if (cpu_i.wr) begin
            case (cpu_i.addr)
                TCSP_ADDR_MODE: begin
                    st_nxt.mode = (st_r.mode & ~cpu_i.wmask) |
                                  (cpu_i.wdata & cpu_i.wmask & 8'hd0);
                    st_nxt.mode[TCSP_MODE_BUSY_BIT] =
                        st_r.mode[TCSP_MODE_BUSY_BIT];
                end
                TCSP_ADDR_CLKSEL: st_nxt.csel = (st_r.csel & ~cpu_i.wmask) |
                                  (cpu_i.wdata & cpu_i.wmask & 8'h1f);
                TCSP_ADDR_TXBUF:  st_nxt.txbuf = (st_r.txbuf & ~cpu_i.wmask) |
                                  (cpu_i.wdata & cpu_i.wmask);
                default: ;
            endcase
        end

        // readback
        case (cpu_i.addr)
            TCSP_ADDR_MODE:   st_nxt.rdata = st_r.mode;
            TCSP_ADDR_CLKSEL: st_nxt.rdata = st_r.csel;
            TCSP_ADDR_TXBUF:  st_nxt.rdata = st_r.txbuf;
            TCSP_ADDR_SHIFT:  st_nxt.rdata = st_r.shift;
            default:          st_nxt.rdata = 8'h00;
        endcase

        // divider only runs while a master transfer is live
        if (st_r.fsm == TCSP_IDLE || tick || slave) begin
            st_nxt.div = 7'h00;
        end else begin
            st_nxt.div = st_r.div + 7'h1;
        end

        case (st_r.fsm)
            TCSP_IDLE: begin
                if (start) begin
                    st_nxt.fsm  = TCSP_LEAD;
                    st_nxt.bits = 4'h0;
                    st_nxt.mode[TCSP_MODE_BUSY_BIT] = 1'b1;
                    if (trmd) begin
                        st_nxt.shift = cpu_i.wdata;
                        // phase types 2/4 present the first bit at once
                        if (dap) begin
                            st_nxt.so = pick_out(cpu_i.wdata, dir);
                        end
                    end
                end
            end
            TCSP_LEAD: begin
                if (lead_edge) begin
                    st_nxt.sck = ~ckp;
                    if (!dap && trmd) begin
                        st_nxt.so = pick_out(st_r.shift, dir);
                    end
                    st_nxt.fsm = TCSP_TRAIL;
                end
            end
            TCSP_TRAIL: begin
                if (trail_edge) begin
                    st_nxt.sck   = ckp;
                    st_nxt.shift = shift_in(st_r.shift, dir, si_sync_r[1]);
                    st_nxt.bits  = st_r.bits + 4'h1;
                    if (st_r.bits == TCSP_BITS - 4'h1) begin
                        st_nxt.fsm  = TCSP_IDLE;
                        st_nxt.done = 1'b1;
                        rx_push     = 1'b1;
                        st_nxt.mode[TCSP_MODE_BUSY_BIT] = 1'b0;
                    end else begin
                        st_nxt.fsm = TCSP_LEAD;
                        if (dap && trmd) begin
                            st_nxt.so = pick_out(
                                shift_in(st_r.shift, dir, si_sync_r[1]), dir);
                        end
                    end
                end
            end
            default: st_nxt.fsm = TCSP_IDLE;
        endcase

        // idle clock level follows polarity when not mid-bit
        if (st_r.fsm == TCSP_IDLE) begin
            st_nxt.sck = ckp;
        end
        // receive-only keeps data out low
        if (!trmd) begin
            st_nxt.so = 1'b0;
        end

        // pins: port pins released unless mode uses them
        st_nxt.pins.sck_out  = st_nxt.sck;
        st_nxt.pins.sck_oe_n = !(st_nxt.mode[TCSP_MODE_EN_BIT] && !slave);
        st_nxt.pins.so_out   = st_nxt.so;
        st_nxt.pins.so_oe_n  = !(st_nxt.mode[TCSP_MODE_EN_BIT] &&
                                 st_nxt.mode[TCSP_MODE_TRMD_BIT]);

        // disable acts as a reset on the serial engine
        if (!st_nxt.mode[TCSP_MODE_EN_BIT]) begin
            st_nxt.fsm   = TCSP_IDLE;
            st_nxt.shift = 8'h00;
            st_nxt.bits  = 4'h0;
            st_nxt.div   = 7'h00;
            st_nxt.sck   = ckp;
            st_nxt.mode[TCSP_MODE_BUSY_BIT] = 1'b0;
            st_nxt.pins.sck_oe_n = 1'b1;
            st_nxt.pins.so_oe_n  = 1'b1;
            rx_push = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r      <= '0;
            st_r.mode <= TCSP_MODE_RST;
            st_r.csel <= TCSP_CLKSEL_RST;
            st_r.pins <= '{sck_out: 1'b0, sck_oe_n: 1'b1,
                           so_out: 1'b0, so_oe_n: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received bytes queue for the consumer; overflow drops silently
    tcsp_fifo #(
        .WIDTH (8),
        .DEPTH (TCSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .clr_i       (!en),
        .in_valid_i  (rx_push),
        .in_ready_o  (rx_room),
        .in_data_i   (st_nxt.shift),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    assign rdata_o         = st_r.rdata;
    assign done_irq_flag_o = st_r.done;
    assign sck_pin_o       = st_r.pins.sck_out;
    assign sck_pin_oe_n_o  = st_r.pins.sck_oe_n;
    assign so_pin_o        = st_r.pins.so_out;
    assign so_pin_oe_n_o   = st_r.pins.so_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (st_r.mode & 8'h2e) == 8'h00 && (st_r.csel & 8'he0) == 8'h00)
        else $error("reserved bits set");
    a_disable_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !en |-> st_r.mode[0] == 1'b0 && st_r.shift == 8'h00)
        else $error("disabled engine not cleared");
    a_start_busy: assert property (@(posedge clk_i) disable iff (!rstn_i)
        start |=> st_r.mode[0] || !en)
        else $error("busy not set after start");
    a_done_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_r.done |-> !st_r.mode[0] && $past(st_r.mode[0]))
        else $error("done without busy end");
    a_eight_bits: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_r.done |-> $past(st_r.bits) == 4'h7)
        else $error("transfer length not eight");
    a_rx_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !trmd && !$past(trmd) |-> !so_pin_o)
        else $error("data out not low in receive mode");
    a_pins_free: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !en && !$past(en) |-> sck_pin_oe_n_o && so_pin_oe_n_o)
        else $error("pins driven while disabled");
    a_stop_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !en |=> st_r.fsm == TCSP_IDLE)
        else $error("traffic while disabled");
    a_fast_clock: assert property (@(posedge clk_i) disable iff (!rstn_i)
        en && !slave && st_r.csel[2:0] == 3'h0 && st_r.fsm == TCSP_LEAD
        |=> st_r.fsm != TCSP_LEAD || !en)
        else $error("divide by two not honoured");
endmodule : tcsp_port

// [tcsp_periph.sv]
`timescale 1ns/100ps
// behavioural peripheral chip on the far side of the three serial lines
module tcsp_periph
    import tcsp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       sck_i,
    input  wire logic       sck_oe_n_i,
    input  wire logic       so_i,
    input  wire logic       ckp_i,
    input  wire logic       dap_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    output logic            si_o,
    output logic [7:0]      rx_o,
    output logic [3:0]      cnt_o
);
    logic       prev_r;
    logic [2:0] idx;

    // idle state before the first frame
    initial begin
        prev_r = 1'b0;
        si_o   = 1'b0;
        rx_o   = 8'h00;
        cnt_o  = 4'h8;
    end

    // bit position of the current beat in the chosen order
    assign idx = lsb_i ? cnt_o[2:0] : ~cnt_o[2:0];

    ////////////////////////////////////////////////////////////////////////
    // edges count only while the device drives the clock; extra edges are
    // not ignored, so a ninth edge shows up in the count
    always @(posedge clk_i) begin
        prev_r <= sck_i;
        if (clr_i) begin
            cnt_o <= 4'h0;
        end else if (!sck_oe_n_i && sck_i != prev_r) begin
            if (sck_i != ckp_i) begin
                si_o <= tx_i[idx];
                if (dap_i) begin
                    rx_o[idx] <= so_i;
                end
            end else begin
                if (!dap_i) begin
                    rx_o[idx] <= so_i;
                end
                cnt_o <= cnt_o + 4'h1;
            end
        end else if (cnt_o == 4'h8) begin
            si_o <= ~si_o; // released line flips so stale data never matches
        end
    end
endmodule : tcsp_periph

// [testbench.sv]
`timescale 1ns/100ps
module testbench import tcsp_pkg::*;;
    logic          clk_i;
    logic          rstn_i;
    tcsp_cpu_req_t cpu;
    logic [7:0]    rdata;
    logic          done;
    logic          sck_o;
    logic          sck_oe_n;
    logic          so_o;
    logic          so_oe_n;
    logic          si;
    logic          sck_w;
    logic          rx_valid;
    logic          rx_ready;
    logic [7:0]    rx_data;
    logic [7:0]    p_tx;
    logic [7:0]    p_rx;
    logic [3:0]    p_cnt;
    logic          p_clr;
    logic          ckp;
    logic          dap;
    logic          lsb;
    int            n_errors;
    int            cmp_count;
    logic [7:0]    exp_q[$];

    // undriven clock pin reads as port latch low
    assign sck_w = sck_oe_n ? 1'b0 : sck_o;

    tcsp_port i_tcsp_port (
        .clk_i(clk_i), .rstn_i(rstn_i), .cpu_i(cpu), .rdata_o(rdata),
        .done_irq_flag_o(done), .sck_pin_i(sck_w), .si_pin_i(si),
        .sck_pin_o(sck_o), .sck_pin_oe_n_o(sck_oe_n), .so_pin_o(so_o),
        .so_pin_oe_n_o(so_oe_n), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .rx_data_o(rx_data)
    );

    tcsp_periph i_tcsp_periph (
        .clk_i(clk_i), .clr_i(p_clr), .sck_i(sck_o), .sck_oe_n_i(sck_oe_n),
        .so_i(so_o), .ckp_i(ckp), .dap_i(dap), .lsb_i(lsb), .tx_i(p_tx),
        .si_o(si), .rx_o(p_rx), .cnt_o(p_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    // one register cycle; address held until the registered answer lands
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [7:0] m,
                       output logic [7:0] q);
        cpu.wr = w;
        cpu.rd = !w;
        cpu.addr = a;
        cpu.wdata = d;
        cpu.wmask = m;
        @(negedge clk_i);
        cpu.wr = 1'b0;
        cpu.rd = 1'b0;
        q = rdata;
    endtask : bus

    task automatic drain();
        logic [7:0] e;
        int         n;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            n = 0;
            while (rx_valid !== 1'b1 && n < 20) begin
                @(negedge clk_i);
                n++;
            end
            chk("rx byte", e, rx_data);
            rx_ready = 1'b1;
            @(negedge clk_i);
            rx_ready = 1'b0;
            @(negedge clk_i);
        end
        chk("fifo empty", 8'h00, {7'h0, rx_valid});
    endtask : drain

    // one whole byte with the given mode, phase type, order and divider
    task automatic xfer(input logic trmd, input logic c_ckp,
                        input logic c_dap, input logic c_dir,
                        input logic [2:0] code);
        logic [7:0] q;
        logic [7:0] d;
        logic [7:0] md;
        int         n;
        d = 8'($urandom);
        p_tx = 8'($urandom);
        ckp = c_ckp;
        dap = c_dap;
        lsb = c_dir;
        md = {1'b1, trmd, 1'b0, c_dir, 4'h0};
        bus(1'b1, TCSP_ADDR_CLKSEL, {3'h0, c_ckp, c_dap, code}, 8'hff, q);
        bus(1'b1, TCSP_ADDR_MODE, md, 8'hff, q);
        p_clr = 1'b1;
        @(negedge clk_i);
        p_clr = 1'b0;
        bus(trmd, trmd ? TCSP_ADDR_TXBUF : TCSP_ADDR_SHIFT, d, 8'hff, q);
        bus(1'b0, TCSP_ADDR_MODE, 8'h00, 8'h00, q);
        chk("busy set", md | 8'h01, q);
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        chk("done pulse", 8'h01, {7'h0, done});
        @(negedge clk_i);
        chk("bits moved", 8'h08, {4'h0, p_cnt});
        chk("peer rx", trmd ? d : 8'h00, p_rx);
        chk("sck idle", {7'h0, c_ckp}, {7'h0, sck_o});
        bus(1'b0, TCSP_ADDR_MODE, 8'h00, 8'h00, q);
        chk("busy clear", md, q);
        if (exp_q.size() < TCSP_FIFO_DEPTH) begin
            exp_q.push_back(p_tx);
        end
        // disabling clears the receive queue, so empty it while enabled
        drain();
        bus(1'b1, TCSP_ADDR_MODE, 8'h00, 8'hff, q);
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////
    // main sequence; dividers 3..6 leave room for the pin synchronisers
    initial begin
        logic [7:0] q;
        int         i;
        int         n;
        n_errors = 0;
        cmp_count = 0;
        cpu = '0;
        rstn_i = 1'b0;
        rx_ready = 1'b0;
        p_clr = 1'b0;
        p_tx = 8'h00;
        ckp = 1'b0;
        dap = 1'b0;
        lsb = 1'b0;
        void'($urandom(40));
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        bus(1'b0, TCSP_ADDR_MODE, 8'h00, 8'h00, q);
        chk("mode reset", TCSP_MODE_RST, q);
        bus(1'b0, TCSP_ADDR_CLKSEL, 8'h00, 8'h00, q);
        chk("clksel reset", TCSP_CLKSEL_RST, q);
        bus(1'b0, 16'hff84, 8'h00, 8'h00, q);
        chk("unmapped", 8'h00, q);
        chk("pins free", 8'h03, {6'h0, sck_oe_n, so_oe_n});
        bus(1'b1, TCSP_ADDR_MODE, 8'h3f, 8'hff, q);
        bus(1'b0, TCSP_ADDR_MODE, 8'h00, 8'h00, q);
        chk("reserved bits", 8'h10, q);
        bus(1'b1, TCSP_ADDR_MODE, 8'h00, 8'hff, q);
        for (i = 0; i < 8; i++) begin
            xfer(1'b1, i[2], i[1], i[0], 3'(3 + $urandom_range(3)));
            if (i == 4) begin
                drain();
            end
        end
        drain();
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
        drain();
        // stop mode in mid-byte through a single-bit write
        ckp = 1'b0;
        dap = 1'b0;
        bus(1'b1, TCSP_ADDR_CLKSEL, 8'h06, 8'hff, q);
        bus(1'b1, TCSP_ADDR_MODE, 8'hc0, 8'hff, q);
        bus(1'b1, TCSP_ADDR_TXBUF, 8'ha5, 8'hff, q);
        repeat (100) @(negedge clk_i);
        bus(1'b1, TCSP_ADDR_MODE, 8'h40, 8'h80, q);
        bus(1'b0, TCSP_ADDR_MODE, 8'h00, 8'h00, q);
        chk("stop mode", 8'h40, q);
        bus(1'b0, TCSP_ADDR_SHIFT, 8'h00, 8'h00, q);
        chk("shift cleared", 8'h00, q);
        n = 0;
        repeat (1000) begin
            @(negedge clk_i);
            if (done !== 1'b0 || sck_oe_n !== 1'b1 || so_oe_n !== 1'b1) begin
                n++;
            end
        end
        chk("stopped pins", 8'h00, 8'(n));
        chk("fifo untouched", 8'h00, {7'h0, rx_valid});
        finish_test();
    end

    // watchdog: the full run needs well under 20000 cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        finish_test();
    end
endmodule : testbench
